// ### verilog/htlc_top.sv
// htlc_top: hdlc test, loopback and fifo swap control with ahb-lite slave
//
// Behaviour
// - soft reset bit resets hdlc like pin
// - bit clears after two zero writes
// - rx loop writes bytes to both fifos
// - looped bytes sent, good and bad
// - crc test shifts 16 clocks then stops
// - crc test expects remainder F0B8
// - every computed crc bit can be flipped
// - fifo test swaps write and read fifo
// - fifo test reroutes tags both ways
// - address test shifts 16 clocks, stops
// - tx loop feeds tx data to rx
// - rx clock view gated by rx enable
// - tx clock view gated by tx enable
// - crc match flag shows compare success
// - address match flag shows compare success
// - upper status bits have no function
`timescale 1ns/10ps
`default_nettype none
module htlc_top #(
  parameter int SHIFT_LEN = htlc_pkg::SHIFT_LEN
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic rx_line_clock_i,
  input wire logic rx_line_data_i,
  input wire logic tx_line_clock_i,
  input wire logic tx_line_data_i,
  output logic rx_serial_o,
  output logic hdlc_reset_o,
  output logic rx_enable_o,
  output logic tx_enable_o,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic [1:0] rx_tag_i,
  input wire logic cpu_wr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic [1:0] cpu_wtag_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] tx_fifo_q_i,
  input wire logic [1:0] tx_fifo_tag_i,
  input wire logic [7:0] rx_fifo_q_i,
  input wire logic [1:0] rx_fifo_tag_i,
  output logic tx_fifo_wr_o,
  output logic [7:0] tx_fifo_wdata_o,
  output logic [1:0] tx_fifo_wtag_o,
  output logic rx_fifo_wr_o,
  output logic [7:0] rx_fifo_wdata_o,
  output logic [1:0] rx_fifo_wtag_o,
  output logic tx_fifo_rd_o,
  output logic rx_fifo_rd_o,
  output logic [7:0] cpu_rdata_o,
  output logic [1:0] fifo_tag_read_bits_o
);
  htlc_pkg::htlc_bus_state_type state_reg, state_next;
  logic dp_wr_reg, dp_hit_reg;
  logic [5:0] dp_idx_reg;
  logic [6:0] ctl_reg, ctl_next;
  logic [1:0] line_reg, line_next;
  logic [15:0] flip_reg, flip_next, pat_reg, pat_next;
  logic rx_clk_q_reg, rx_view_reg, tx_view_reg;
  logic srst_q, crc_match, addr_match, crc_done, addr_done;
  logic [31:0] rd_mux;
  logic [7:0] ctl_rd, stat_rd;

  // address phase decode; only word-aligned addresses in the low page are mapped, and only word-size writes are taken
  wire addr_take = hsel_i & hready_i & htrans_i[1];
  wire addr_hit = (haddr_i[31:8] == 24'h0) & (haddr_i[1:0] == 2'h0);
  wire word_wr = hwrite_i & (hsize_i == htlc_pkg::HSIZE_WORD);
  wire wr_now = dp_wr_reg & dp_hit_reg;
  wire wr_ctl = wr_now & (dp_idx_reg == htlc_pkg::IDX_TEST_CTRL);
  wire wr_line = wr_now & (dp_idx_reg == htlc_pkg::IDX_LINE_CTRL);
  wire wr_flip = wr_now & (dp_idx_reg == htlc_pkg::IDX_CRC_FLIP);
  wire wr_pat = wr_now & (dp_idx_reg == htlc_pkg::IDX_ADDR_PAT);

  // hdlc reset is held for the whole soft reset, and from the write itself
  wire clr_now = srst_q | (wr_ctl & hwdata_i[htlc_pkg::CTL_SRST]);

  // soft reset bit lives in its own unit
  htlc_soft_rst u_srst (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .wr_i(wr_ctl),
    .bit_i(hwdata_i[htlc_pkg::CTL_SRST]),
    .srst_o(srst_q)
  );

  // control state next values; soft reset clears all but its own bit
  assign ctl_next = clr_now ? htlc_pkg::CTL_RESET :
    (wr_ctl ? hwdata_i[6:0] : ctl_reg);
  assign line_next = clr_now ? htlc_pkg::LINE_RESET :
    (wr_line ? hwdata_i[1:0] : line_reg);
  assign flip_next = clr_now ? htlc_pkg::PAT_RESET :
    (wr_flip ? hwdata_i[15:0] : flip_reg);
  assign pat_next = clr_now ? htlc_pkg::PAT_RESET :
    (wr_pat ? hwdata_i[15:0] : pat_reg);

  wire rt_loop = ctl_reg[htlc_pkg::CTL_RX_TO_TX_LOOP];
  wire swap = ctl_reg[htlc_pkg::CTL_FIFO_SWAP_TEST];
  wire rx_en = line_reg[htlc_pkg::LINE_RX_ENABLE_BIT];
  wire tx_en = line_reg[htlc_pkg::LINE_TX_ENABLE_BIT];

  // registers written from the bus
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctl_reg <= htlc_pkg::CTL_RESET;
      line_reg <= htlc_pkg::LINE_RESET;
      flip_reg <= htlc_pkg::PAT_RESET;
      pat_reg <= htlc_pkg::PAT_RESET;
    end else if (ce_i) begin
      ctl_reg <= ctl_next;
      line_reg <= line_next;
      flip_reg <= flip_next;
      pat_reg <= pat_next;
    end
  end

  // read data; reserved control bits read back as written
  assign ctl_rd = {srst_q, ctl_reg};
  assign stat_rd = {4'h0, rx_view_reg, tx_view_reg,
    crc_match, addr_match};
  assign rd_mux = !dp_hit_reg ? 32'h0 :
    (dp_idx_reg == htlc_pkg::IDX_TEST_CTRL) ? {24'h0, ctl_rd} :
    (dp_idx_reg == htlc_pkg::IDX_TEST_STAT) ? {24'h0, stat_rd} :
    (dp_idx_reg == htlc_pkg::IDX_LINE_CTRL) ? {30'h0, line_reg} :
    (dp_idx_reg == htlc_pkg::IDX_CRC_FLIP) ? {16'h0, flip_reg} :
    (dp_idx_reg == htlc_pkg::IDX_ADDR_PAT) ? {16'h0, pat_reg} : 32'h0;

  // reads take one wait state so a preceding write is already visible
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      htlc_pkg::BUS_IDLE: begin
        if (addr_take && !hwrite_i) begin
          state_next = htlc_pkg::BUS_RWAIT;
        end
      end
      htlc_pkg::BUS_RWAIT: begin
        state_next = htlc_pkg::BUS_IDLE;
      end
      default: begin
        state_next = htlc_pkg::BUS_IDLE;
      end
    endcase
  end

  // bus slave state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_reg <= htlc_pkg::BUS_IDLE;
      dp_wr_reg <= 1'b0;
      dp_hit_reg <= 1'b0;
      dp_idx_reg <= 6'h0;
      hrdata_o <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o <= htlc_pkg::HRESP_OKAY;
    end else if (ce_i) begin
      state_reg <= state_next;
      dp_wr_reg <= addr_take & word_wr;
      if (addr_take) begin
        dp_hit_reg <= addr_hit;
        dp_idx_reg <= haddr_i[7:2];
      end
      if (state_reg == htlc_pkg::BUS_RWAIT) begin
        hrdata_o <= rd_mux;
      end
      hreadyout_o <= (state_next != htlc_pkg::BUS_RWAIT);
      hresp_o <= htlc_pkg::HRESP_OKAY;
    end
  end

  // fifo routing; receiver writes win over a processor write on a clash
  wire cpu_to_tx = cpu_wr_i & ~swap;
  wire cpu_to_rx = cpu_wr_i & swap;
  wire rx_to_tx = rx_byte_valid_i & rt_loop;
  wire tx_wr_next = ~clr_now & (rx_to_tx | cpu_to_tx);
  wire rx_wr_next = ~clr_now & (rx_byte_valid_i | cpu_to_rx);

  // fifo write and read strobes, all from flip-flops
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_fifo_wr_o <= 1'b0;
      tx_fifo_wdata_o <= 8'h00;
      tx_fifo_wtag_o <= 2'h0;
      rx_fifo_wr_o <= 1'b0;
      rx_fifo_wdata_o <= 8'h00;
      rx_fifo_wtag_o <= 2'h0;
      tx_fifo_rd_o <= 1'b0;
      rx_fifo_rd_o <= 1'b0;
      cpu_rdata_o <= 8'h00;
      fifo_tag_read_bits_o <= 2'h0;
    end else if (ce_i) begin
      tx_fifo_wr_o <= tx_wr_next;
      // bad packets keep their tag and are looped all the same
      tx_fifo_wdata_o <= rx_to_tx ? rx_byte_i : cpu_wdata_i;
      tx_fifo_wtag_o <= rx_to_tx ? rx_tag_i : cpu_wtag_i;
      rx_fifo_wr_o <= rx_wr_next;
      rx_fifo_wdata_o <= rx_byte_valid_i ? rx_byte_i : cpu_wdata_i;
      rx_fifo_wtag_o <= rx_byte_valid_i ? rx_tag_i : cpu_wtag_i;
      tx_fifo_rd_o <= ~clr_now & cpu_rd_i & swap;
      rx_fifo_rd_o <= ~clr_now & cpu_rd_i & ~swap;
      if (cpu_rd_i) begin
        cpu_rdata_o <= swap ? tx_fifo_q_i : rx_fifo_q_i;
        fifo_tag_read_bits_o <= swap ? tx_fifo_tag_i : rx_fifo_tag_i;
      end
    end
  end

  // line side; the line clocks are sampled as ordinary inputs
  wire rx_rise = rx_line_clock_i & ~rx_clk_q_reg;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_clk_q_reg <= 1'b0;
      rx_view_reg <= 1'b0;
      tx_view_reg <= 1'b0;
      rx_serial_o <= 1'b0;
      hdlc_reset_o <= 1'b1;
      rx_enable_o <= 1'b0;
      tx_enable_o <= 1'b0;
    end else if (ce_i) begin
      rx_clk_q_reg <= rx_line_clock_i;
      rx_view_reg <= rx_line_clock_i & rx_en;
      tx_view_reg <= tx_line_clock_i & tx_en;
      // loop is not gated by the enables; software sets them both
      rx_serial_o <= ctl_reg[htlc_pkg::CTL_TX_TO_RX_LOOP] ?
        tx_line_data_i : rx_line_data_i;
      hdlc_reset_o <= clr_now;
      rx_enable_o <= line_next[htlc_pkg::LINE_RX_ENABLE_BIT];
      tx_enable_o <= line_next[htlc_pkg::LINE_TX_ENABLE_BIT];
    end
  end

  // serial compare units; leaving a test clears its register
  htlc_shift_cmp #(
    .LEN(SHIFT_LEN)
  ) u_crc (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    // next value, so the flag drops in the same edge as the test bit
    .clr_i(clr_now | ~ctl_next[htlc_pkg::CTL_CRC_REMAINDER_TEST]),
    .shift_i(rx_rise),
    .data_i(rx_line_data_i),
    .pattern_i(htlc_pkg::CRC_PATTERN),
    .flip_i(flip_reg),
    .match_o(crc_match),
    .done_o(crc_done)
  );
  htlc_shift_cmp #(
    .LEN(SHIFT_LEN)
  ) u_addr (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clr_i(clr_now | ~ctl_next[htlc_pkg::CTL_ADDR_MATCH_TEST]),
    .shift_i(rx_rise),
    .data_i(rx_line_data_i),
    .pattern_i(pat_reg),
    .flip_i(16'h0000),
    .match_o(addr_match),
    .done_o(addr_done)
  );

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i || !ce_i);

  a_srst_resets_hdlc: assert property (
    wr_ctl && hwdata_i[7] |=> srst_q && ctl_reg == 7'h00 ##1 hdlc_reset_o)
    else $error("soft reset did not reset the hdlc");
  a_loop_both_fifos: assert property (
    rx_byte_valid_i && rt_loop && !clr_now
    |=> tx_fifo_wr_o && rx_fifo_wr_o && tx_fifo_wdata_o == $past(rx_byte_i))
    else $error("looped byte missing from a fifo");
  a_loop_keeps_tag: assert property (
    rx_byte_valid_i && rt_loop && !clr_now
    |=> tx_fifo_wtag_o == $past(rx_tag_i))
    else $error("looped tag altered");
  a_crc_needs_test: assert property (
    crc_match |-> ctl_reg[3] && crc_done)
    else $error("crc match outside crc test");
  a_swap_write: assert property (
    cpu_wr_i && swap && !rx_byte_valid_i && !clr_now
    |=> rx_fifo_wr_o && !tx_fifo_wr_o && rx_fifo_wtag_o == $past(cpu_wtag_i))
    else $error("swapped write went to wrong fifo");
  a_swap_tag_read: assert property (
    cpu_rd_i && swap && !clr_now
    |=> tx_fifo_rd_o && fifo_tag_read_bits_o == $past(tx_fifo_tag_i))
    else $error("swapped read shows wrong tag");
  a_tx_rx_loop: assert property (
    ctl_reg[0] |=> rx_serial_o == $past(tx_line_data_i))
    else $error("tx data not fed to rx input");
  a_rx_view_gate: assert property (
    !rx_en |=> !rx_view_reg)
    else $error("rx clock view not gated");
  a_tx_view_gate: assert property (
    tx_line_clock_i && tx_en |=> tx_view_reg)
    else $error("tx clock view missing");
  a_stat_flags: assert property (
    state_reg == htlc_pkg::BUS_RWAIT && dp_hit_reg && dp_idx_reg == 6'h1C
    |=> hrdata_o[1] == $past(crc_match) && hrdata_o[0] == $past(addr_match))
    else $error("status flags read wrong");
  a_stat_rsv_zero: assert property (
    state_reg == htlc_pkg::BUS_RWAIT && dp_idx_reg == 6'h1C
    |=> hrdata_o[31:4] == 28'h0)
    else $error("reserved status bits not zero");

  c_crc_match: cover property (ctl_reg[3] ##[1:1000] crc_match);
  c_addr_match: cover property (ctl_reg[1] ##[1:1000] addr_match);
  c_srst_cycle: cover property (srst_q ##[1:50] !srst_q);
  c_loop_byte: cover property (rx_byte_valid_i && rt_loop && swap);
endmodule
`default_nettype wire

// ### inc/htlc_pkg.sv
// htlc_pkg: constants and types for the hdlc test and loopback block
package htlc_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_TEST_CTRL = 6'h1B;
  localparam logic [5:0] IDX_TEST_STAT = 6'h1C;
  localparam logic [5:0] IDX_CRC_FLIP = 6'h20;
  localparam logic [5:0] IDX_LINE_CTRL = 6'h21;
  localparam logic [5:0] IDX_ADDR_PAT = 6'h22;
  // test control fields
  localparam int CTL_SRST = 7;
  localparam int CTL_RX_TO_TX_LOOP = 6;
  localparam int CTL_CRC_REMAINDER_TEST = 3;
  localparam int CTL_FIFO_SWAP_TEST = 2;
  localparam int CTL_ADDR_MATCH_TEST = 1;
  localparam int CTL_TX_TO_RX_LOOP = 0;
  localparam logic [6:0] CTL_RESET = 7'h00;
  // test status fields
  localparam int STAT_RX_CLOCK_VIEW = 3;
  localparam int STAT_TX_CLOCK_VIEW = 2;
  localparam int STAT_CRC_MATCH_FLAG = 1;
  localparam int STAT_ADDR_MATCH_FLAG = 0;
  // line control fields
  localparam int LINE_RX_ENABLE_BIT = 0;
  localparam int LINE_TX_ENABLE_BIT = 1;
  localparam logic [1:0] LINE_RESET = 2'h0;
  // serial compare units, soft reset zero write count and tag width
  localparam int SHIFT_LEN = 16;
  localparam logic [15:0] CRC_PATTERN = 16'hF0B8;
  localparam logic [15:0] PAT_RESET = 16'h0000;
  localparam int SRST_ZERO_WRITES = 2;
  localparam int TAG_W = 2;
  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_RWAIT = 1'b1
  } htlc_bus_state_type;
endpackage

// ### verilog/htlc_shift_cmp.sv
// htlc_shift_cmp: serial load register that stops when aligned, with compare
`timescale 1ns/10ps
`default_nettype none
module htlc_shift_cmp #(
  parameter int LEN = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic shift_i,
  input wire logic data_i,
  input wire logic [LEN-1:0] pattern_i,
  input wire logic [LEN-1:0] flip_i,
  output logic match_o,
  output logic done_o
);
  localparam int CW = $clog2(LEN + 1);
  logic [LEN-1:0] sr_reg, sr_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic full, step, match_next;

  // the clock is stopped once LEN bits are in
  assign full = (cnt_reg == CW'(LEN));
  assign step = shift_i & ~full;
  assign sr_next = clr_i ? '0 : (step ? {sr_reg[LEN-2:0], data_i} : sr_reg);
  assign cnt_next = clr_i ? '0 : (step ? cnt_reg + 1'b1 : cnt_reg);
  // flip bits corrupt the loaded value before the compare
  assign match_next = ~clr_i & (cnt_next == CW'(LEN))
    & ((sr_next ^ flip_i) == pattern_i);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sr_reg <= '0;
      cnt_reg <= '0;
      match_o <= 1'b0;
    end else if (ce_i) begin
      sr_reg <= sr_next;
      cnt_reg <= cnt_next;
      match_o <= match_next;
    end
  end
  assign done_o = full;

  a_shift_stops: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || !ce_i) full && !clr_i |=> $stable(sr_reg))
    else $error("shift register moved after alignment");
  a_match_flip: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || !ce_i)
    match_o |-> full && ((sr_reg ^ flip_i) == pattern_i))
    else $error("match without corrupted compare");
endmodule
`default_nettype wire

// ### verilog/htlc_soft_rst.sv
// htlc_soft_rst: soft reset bit that needs two zero writes to clear
`timescale 1ns/10ps
`default_nettype none
module htlc_soft_rst (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic bit_i,
  output logic srst_o
);
  logic [1:0] zc_reg, zc_next;
  logic srst_next, last_zero;

  // a one write restarts the count of zero writes
  assign last_zero = (zc_reg == 2'(htlc_pkg::SRST_ZERO_WRITES - 1));
  assign srst_next = wr_i ? (bit_i | (srst_o & ~last_zero)) : srst_o;
  assign zc_next = (!wr_i) ? zc_reg :
    ((bit_i || !srst_o || last_zero) ? 2'h0 : zc_reg + 2'h1);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      srst_o <= 1'b0;
      zc_reg <= 2'h0;
    end else if (ce_i) begin
      srst_o <= srst_next;
      zc_reg <= zc_next;
    end
  end

  a_srst_two_zeros: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i || !ce_i)
    $fell(srst_o) |-> $past(wr_i && !bit_i && zc_reg == 2'h1))
    else $error("soft reset cleared without second zero write");
endmodule
`default_nettype wire

// ### dv/test_hdlc_test_loopback_control.sv
// test_hdlc_test_loopback_control: register and port bench for the test block
`timescale 1ns/10ps
`default_nettype none
module test_hdlc_test_loopback_control;
  logic clk_sys_i, rst_n_i, ce_i, hsel_i, hwrite_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0] htrans_i, rx_tag_i, cpu_wtag_i, tx_fifo_tag_i, rx_fifo_tag_i;
  logic [2:0] hsize_i;
  logic rx_line_clock_i, rx_line_data_i, tx_line_clock_i, tx_line_data_i;
  logic rx_byte_valid_i, cpu_wr_i, cpu_rd_i;
  logic [7:0] rx_byte_i, cpu_wdata_i, tx_fifo_q_i, rx_fifo_q_i;
  logic hreadyout_o, hresp_o, rx_serial_o, hdlc_reset_o;
  logic rx_enable_o, tx_enable_o, tx_fifo_wr_o, rx_fifo_wr_o;
  logic tx_fifo_rd_o, rx_fifo_rd_o;
  logic [7:0] tx_fifo_wdata_o, rx_fifo_wdata_o, cpu_rdata_o;
  logic [1:0] tx_fifo_wtag_o, rx_fifo_wtag_o, fifo_tag_read_bits_o;
  wire logic hready_i;
  int fails = 0;
  int samples_checked = 0;

  // single slave, so its ready is the bus ready
  assign hready_i = hreadyout_o;

  htlc_top i_dut (.clk_sys_i, .rst_n_i, .ce_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
    .hresp_o, .rx_line_clock_i, .rx_line_data_i, .tx_line_clock_i,
    .tx_line_data_i, .rx_serial_o, .hdlc_reset_o, .rx_enable_o,
    .tx_enable_o, .rx_byte_valid_i, .rx_byte_i, .rx_tag_i, .cpu_wr_i,
    .cpu_wdata_i, .cpu_wtag_i, .cpu_rd_i, .tx_fifo_q_i, .tx_fifo_tag_i,
    .rx_fifo_q_i, .rx_fifo_tag_i, .tx_fifo_wr_o, .tx_fifo_wdata_o,
    .tx_fifo_wtag_o, .rx_fifo_wr_o, .rx_fifo_wdata_o, .rx_fifo_wtag_o,
    .tx_fifo_rd_o, .rx_fifo_rd_o, .cpu_rdata_o, .fifo_tag_read_bits_o);

  // 25 mhz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic conclude();
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_reg(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_pin(input string name, input logic [7:0] exp,
    input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one single word transfer; waits on ready, the watchdog ends a hang
  task automatic bus_xfer(input logic [5:0] idx, input logic wr,
    input logic [31:0] wd, output logic [31:0] rd);
    hsel_i <= 1'b1;
    haddr_i <= {24'h000000, idx, 2'b00};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    hsize_i <= htlc_pkg::HSIZE_WORD;
    do @(posedge clk_sys_i); while (hready_i !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_sys_i); while (hready_i !== 1'b1);
    rd = hrdata_o;
  endtask

  task automatic wr_reg(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] unused;
    bus_xfer(idx, 1'b1, d, unused);
  endtask

  task automatic rd_chk(input string name, input logic [5:0] idx,
    input logic [31:0] exp);
    logic [31:0] v;
    bus_xfer(idx, 1'b0, 32'h00000000, v);
    check_reg(name, exp, v);
  endtask

  // sixteen line clock rises, most significant bit first
  task automatic shift16(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      rx_line_data_i <= v[i];
      repeat (2) @(posedge clk_sys_i);
      rx_line_clock_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rx_line_clock_i <= 1'b0;
    end
  endtask

  // let the edge's updates land, then look at registered outputs
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    repeat (8000) @(posedge clk_sys_i);
    fails++;
    conclude();
  end

  initial begin
    {rst_n_i, hsel_i, hwrite_i, rx_line_clock_i, rx_line_data_i} = '0;
    {tx_line_clock_i, tx_line_data_i, rx_byte_valid_i} = '0;
    {cpu_wr_i, cpu_rd_i, rx_tag_i, cpu_wtag_i} = '0;
    {haddr_i, hwdata_i, htrans_i, hsize_i} = '0;
    {rx_byte_i, cpu_wdata_i, rx_fifo_q_i, rx_fifo_tag_i} = '0;
    tx_fifo_q_i = 8'h3C;
    tx_fifo_tag_i = 2'h1;
    ce_i = 1'b1;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_chk("ctrl_reset", htlc_pkg::IDX_TEST_CTRL, 32'h00000000);
    check_pin("hresp_okay", 8'h00, {7'h00, hresp_o});
    rd_chk("stat_reset", htlc_pkg::IDX_TEST_STAT, 32'h00000000);
    rd_chk("unmapped", 6'h3F, 32'h00000000);
    check_pin("hdlc_rst_idle", 8'h00, {7'h00, hdlc_reset_o});
    // soft reset, then a cpu write that must not reach a fifo
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h000000C0);
    settle(2);
    check_pin("hdlc_rst_soft", 8'h01, {7'h00, hdlc_reset_o});
    rd_chk("ctrl_soft", htlc_pkg::IDX_TEST_CTRL, 32'h00000080);
    cpu_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    cpu_wr_i <= 1'b0;
    settle(0);
    check_pin("wr_in_reset", 8'h00, {7'h00, tx_fifo_wr_o});
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000000);
    rd_chk("ctrl_one_zero", htlc_pkg::IDX_TEST_CTRL, 32'h00000080);
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000000);
    rd_chk("ctrl_two_zero", htlc_pkg::IDX_TEST_CTRL, 32'h00000000);
    settle(2);
    check_pin("hdlc_rst_free", 8'h00, {7'h00, hdlc_reset_o});
    // receive to transmit loop: one byte reaches both fifos with its tag
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000040);
    rx_byte_i <= 8'hA5;
    rx_tag_i <= 2'h2;
    rx_byte_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    rx_byte_valid_i <= 1'b0;
    settle(0);
    check_pin("loop_strobes", 8'h03, {6'h00, tx_fifo_wr_o, rx_fifo_wr_o});
    check_pin("loop_tx_data", 8'hA5, tx_fifo_wdata_o);
    check_pin("loop_rx_data", 8'hA5, rx_fifo_wdata_o);
    check_pin("loop_tags", 8'h0A, {4'h0, tx_fifo_wtag_o, rx_fifo_wtag_o});
    settle(1);
    check_pin("loop_pulse", 8'h00, {6'h00, tx_fifo_wr_o, rx_fifo_wr_o});
    // fifo swap: cpu write lands in the rx fifo, cpu read pops the tx fifo
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000004);
    cpu_wdata_i <= 8'h5A;
    cpu_wtag_i <= 2'h3;
    cpu_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    cpu_wr_i <= 1'b0;
    cpu_rd_i <= 1'b1;
    settle(0);
    check_pin("swap_wr", 8'h01, {6'h00, tx_fifo_wr_o, rx_fifo_wr_o});
    check_pin("swap_wdata", 8'h5A, rx_fifo_wdata_o);
    check_pin("swap_wtag", 8'h03, {6'h00, rx_fifo_wtag_o});
    @(posedge clk_sys_i);
    cpu_rd_i <= 1'b0;
    settle(0);
    check_pin("swap_rd", 8'h02, {6'h00, tx_fifo_rd_o, rx_fifo_rd_o});
    check_pin("swap_rdata", 8'h3C, cpu_rdata_o);
    check_pin("swap_rtag", 8'h01, {6'h00, fifo_tag_read_bits_o});
    // crc remainder test: match, then extra rises are ignored
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000008);
    shift16(16'hF0B8);
    shift16(16'h0F47);
    rd_chk("crc_match", htlc_pkg::IDX_TEST_STAT, 32'h00000002);
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000000);
    rd_chk("crc_cleared", htlc_pkg::IDX_TEST_STAT, 32'h00000000);
    // one flipped crc bit breaks the pattern, and repairs it when matched
    wr_reg(htlc_pkg::IDX_CRC_FLIP, 32'h00000001);
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000008);
    shift16(16'hF0B8);
    rd_chk("crc_flip_bad", htlc_pkg::IDX_TEST_STAT, 32'h00000000);
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000000);
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000008);
    shift16(16'hF0B9);
    rd_chk("crc_flip_ok", htlc_pkg::IDX_TEST_STAT, 32'h00000002);
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000000);
    // address recognition test against the programmed pattern
    wr_reg(htlc_pkg::IDX_ADDR_PAT, 32'h00001234);
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000002);
    shift16(16'h1234);
    shift16(16'hFFFF);
    rd_chk("addr_match", htlc_pkg::IDX_TEST_STAT, 32'h00000001);
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000000);
    // transmit to receive loop with both enables set
    wr_reg(htlc_pkg::IDX_LINE_CTRL, 32'h00000003);
    settle(0);
    check_pin("enables", 8'h03, {6'h00, rx_enable_o, tx_enable_o});
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000001);
    tx_line_data_i <= 1'b1;
    rx_line_data_i <= 1'b0;
    settle(2);
    check_pin("tx_loop_hi", 8'h01, {7'h00, rx_serial_o});
    tx_line_data_i <= 1'b0;
    rx_line_data_i <= 1'b1;
    settle(2);
    check_pin("tx_loop_lo", 8'h00, {7'h00, rx_serial_o});
    wr_reg(htlc_pkg::IDX_TEST_CTRL, 32'h00000000);
    settle(2);
    check_pin("no_loop", 8'h01, {7'h00, rx_serial_o});
    // clock views follow the line clocks only when enabled
    wr_reg(htlc_pkg::IDX_LINE_CTRL, 32'h00000001);
    rx_line_clock_i <= 1'b1;
    tx_line_clock_i <= 1'b1;
    rd_chk("view_rx_only", htlc_pkg::IDX_TEST_STAT, 32'h00000008);
    wr_reg(htlc_pkg::IDX_LINE_CTRL, 32'h00000002);
    rd_chk("view_tx_only", htlc_pkg::IDX_TEST_STAT, 32'h00000004);
    // software loop: pop the rx fifo, then write the byte and tag to tx
    rx_fifo_q_i <= 8'h77;
    rx_fifo_tag_i <= 2'h2;
    cpu_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    cpu_rd_i <= 1'b0;
    settle(0);
    check_pin("sw_loop_rd", 8'h77, cpu_rdata_o);
    check_pin("sw_loop_rtag", 8'h02, {6'h00, fifo_tag_read_bits_o});
    cpu_wdata_i <= 8'h77;
    cpu_wtag_i <= 2'h2;
    cpu_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    cpu_wr_i <= 1'b0;
    settle(0);
    check_pin("sw_loop_wr", 8'h77, tx_fifo_wdata_o);
    check_pin("sw_loop_wtag", 8'h06, {5'h00, tx_fifo_wr_o, tx_fifo_wtag_o});
    // clock enable low freezes the strobes
    ce_i <= 1'b0;
    cpu_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    cpu_rd_i <= 1'b0;
    ce_i <= 1'b1;
    settle(0);
    check_pin("ce_freeze", 8'h00, {7'h00, rx_fifo_rd_o});
    conclude();
  end
endmodule
`default_nettype wire
